// ==== ccct_top.sv ====
// Cascaded capture/compare timer with AHB-Lite register slave
`timescale 1ns/1ps
module ccct_top
  import ccct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // A pins of channels 0..2
  input wire logic [2:0] pin_a_in,
  output logic [2:0] pin_a_out,
  output logic [2:0] pin_a_oe,
  // Interrupt
  output logic irq
);
  // Software registers
  logic [2:0] count_start_reg;
  logic timer_mode_reg;
  logic [2:0] output_enable_reg;
  logic [1:0] capture_merge_control;
  logic [3:0] io_control_ch0;
  logic [3:0] io_control_ch1;
  logic [3:0] io_control_ch2;
  logic [15:0] general_reg_a_ch0;
  logic [15:0] general_reg_a_ch1;
  logic [15:0] general_reg_a_ch2;
  logic [2:0] pin_function_selector;
  logic [5:0] status;
  logic [5:0] mask;
  // Bus pipeline
  logic wr_q;
  logic [7:0] addr_q;

  // Counter state
  logic [15:0] cnt0;
  logic [15:0] upper_counter_ch1;
  logic [15:0] lower_counter_ch2;
  logic carry2;

  // Address phase and write decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] aoff = haddr[7:0];
  wire we_start = wr_q && (addr_q == OFF_START);
  wire we_mode = wr_q && (addr_q == OFF_MODE);
  wire we_oe = wr_q && (addr_q == OFF_OE);
  wire we_merge = wr_q && (addr_q == OFF_MERGE);
  wire we_io0 = wr_q && (addr_q == OFF_IO0);
  wire we_io1 = wr_q && (addr_q == OFF_IO1);
  wire we_io2 = wr_q && (addr_q == OFF_IO2);
  wire we_gra0 = wr_q && (addr_q == OFF_GRA0);
  wire we_gra1 = wr_q && (addr_q == OFF_GRA1);
  wire we_gra2 = wr_q && (addr_q == OFF_GRA2);
  wire we_cnt0 = wr_q && (addr_q == OFF_CNT0);
  wire we_cnt1 = wr_q && (addr_q == OFF_CNT1);
  wire we_cnt2 = wr_q && (addr_q == OFF_CNT2);
  wire we_status = wr_q && (addr_q == OFF_STATUS);
  wire we_mask = wr_q && (addr_q == OFF_MASK);
  wire we_pfsel = wr_q && (addr_q == OFF_PFSEL);

  // Pin and control aliases
  wire pin_ch0_a = pin_a_in[0];
  wire pin_ch1_a = pin_a_in[1];
  wire pin_ch2_a = pin_a_in[2];
  wire cascade = timer_mode_reg;
  wire merge_pin2a_enable = capture_merge_control[MERGE_PIN2A_BIT];
  wire merge_pin1a_enable = capture_merge_control[MERGE_PIN1A_BIT];

  // Merged capture conditions, only while cascaded
  wire cond1 = pin_ch1_a | (cascade & merge_pin2a_enable & pin_ch2_a);
  wire cond2 = pin_ch2_a | (cascade & merge_pin1a_enable & pin_ch1_a);

  // Cascaded ch1 advances on ch2 wrap only
  wire inc1 = count_start_reg[1] & (cascade ? carry2 : 1'b1);

  ccct_counter16 u_cnt0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .inc(count_start_reg[0]),
    .load(we_cnt0),
    .load_val(hwdata[15:0]),
    .count(cnt0),
    .carry()
  );

  ccct_counter16 u_cnt1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .inc(inc1),
    .load(we_cnt1),
    .load_val(hwdata[15:0]),
    .count(upper_counter_ch1),
    .carry()
  );

  ccct_counter16 u_cnt2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .inc(count_start_reg[2]),
    .load(we_cnt2),
    .load_val(hwdata[15:0]),
    .count(lower_counter_ch2),
    .carry(carry2)
  );

  // Compare matches, only meaningful while counting
  wire match0 = count_start_reg[0] && (cnt0 == general_reg_a_ch0);
  wire match1 = count_start_reg[1] && (upper_counter_ch1 == general_reg_a_ch1);
  wire match2 = count_start_reg[2] && (lower_counter_ch2 == general_reg_a_ch2);

  // Captures
  logic cap0;
  logic cap1;
  logic cap2;
  wire ch0_event = (match0 & is_output(io_control_ch0)) | cap0;

  ccct_capsel u_cap0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(io_control_ch0),
    .sig(pin_ch0_a),
    .evt(1'b0),
    .hit(cap0)
  );

  ccct_capsel u_cap1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(io_control_ch1),
    .sig(cond1),
    .evt(ch0_event),
    .hit(cap1)
  );

  ccct_capsel u_cap2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(io_control_ch2),
    .sig(cond2),
    .evt(ch0_event),
    .hit(cap2)
  );

  // Capture beats a bus write to the same register
  wire [15:0] next_gra0 = cap0 ? cnt0 : (we_gra0 ? hwdata[15:0] : general_reg_a_ch0);
  wire [15:0] next_gra1 = cap1 ? upper_counter_ch1 : (we_gra1 ? hwdata[15:0] : general_reg_a_ch1);
  wire [15:0] next_gra2 = cap2 ? lower_counter_ch2 : (we_gra2 ? hwdata[15:0] : general_reg_a_ch2);

  // Compare output levels
  function automatic logic out_next(input logic [3:0] mode, input logic we, input logic [3:0] wmode,
                                    input logic hit, input logic cur);
    if (we && is_output(wmode)) begin
      out_next = init_level(wmode);
    end else if (hit && is_output(mode)) begin
      out_next = match_level(mode, cur);
    end else begin
      out_next = cur;
    end
  endfunction : out_next

  wire [2:0] next_out = {
    out_next(io_control_ch2, we_io2, hwdata[3:0], match2, pin_a_out[2]),
    out_next(io_control_ch1, we_io1, hwdata[3:0], match1, pin_a_out[1]),
    out_next(io_control_ch0, we_io0, hwdata[3:0], match0, pin_a_out[0])
  };
  // Pin driven only once the timer function is selected and enabled
  wire [2:0] next_oe = pin_function_selector & output_enable_reg;

  // Sticky status: a new event wins over a write-one clear
  wire [5:0] events = {cap2, cap1, cap0, match2, match1, match0};
  wire [5:0] clr = we_status ? hwdata[5:0] : 6'h00;
  wire [5:0] next_status = (status & ~clr) | events;
  wire [5:0] next_mask = we_mask ? hwdata[5:0] : mask;

  // Read mux, unmapped offsets read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      OFF_START: rd_mux = {29'h0, count_start_reg};
      OFF_MODE: rd_mux = {31'h0, timer_mode_reg};
      OFF_OE: rd_mux = {29'h0, output_enable_reg};
      OFF_MERGE: rd_mux = {30'h0, capture_merge_control};
      OFF_IO0: rd_mux = {28'h0, io_control_ch0};
      OFF_IO1: rd_mux = {28'h0, io_control_ch1};
      OFF_IO2: rd_mux = {28'h0, io_control_ch2};
      OFF_GRA0: rd_mux = {16'h0, general_reg_a_ch0};
      OFF_GRA1: rd_mux = {16'h0, general_reg_a_ch1};
      OFF_GRA2: rd_mux = {16'h0, general_reg_a_ch2};
      OFF_CNT0: rd_mux = {16'h0, cnt0};
      OFF_CNT1: rd_mux = {16'h0, upper_counter_ch1};
      OFF_CNT2: rd_mux = {16'h0, lower_counter_ch2};
      OFF_STATUS: rd_mux = {26'h0, status};
      OFF_MASK: rd_mux = {26'h0, mask};
      OFF_PFSEL: rd_mux = {29'h0, pin_function_selector};
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_q <= addr_phase & hwrite;
      addr_q <= addr_phase ? aoff : addr_q;
      hrdata <= (addr_phase && !hwrite) ? rd_mux(aoff) : hrdata;
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_start_reg <= 3'h0;
      timer_mode_reg <= TIMER_MODE_RESET;
      output_enable_reg <= 3'h0;
      capture_merge_control <= 2'h0;
      pin_function_selector <= 3'h0;
    end else begin
      count_start_reg <= we_start ? hwdata[2:0] : count_start_reg;
      timer_mode_reg <= we_mode ? hwdata[MODE_CASCADE_BIT] : timer_mode_reg;
      output_enable_reg <= we_oe ? hwdata[2:0] : output_enable_reg;
      capture_merge_control <= we_merge ? hwdata[1:0] : capture_merge_control;
      pin_function_selector <= we_pfsel ? hwdata[2:0] : pin_function_selector;
    end
  end

  // Channel registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_control_ch0 <= IO_RESET;
      io_control_ch1 <= IO_RESET;
      io_control_ch2 <= IO_RESET;
      general_reg_a_ch0 <= GRA_RESET;
      general_reg_a_ch1 <= GRA_RESET;
      general_reg_a_ch2 <= GRA_RESET;
    end else begin
      io_control_ch0 <= we_io0 ? hwdata[3:0] : io_control_ch0;
      io_control_ch1 <= we_io1 ? hwdata[3:0] : io_control_ch1;
      io_control_ch2 <= we_io2 ? hwdata[3:0] : io_control_ch2;
      general_reg_a_ch0 <= next_gra0;
      general_reg_a_ch1 <= next_gra1;
      general_reg_a_ch2 <= next_gra2;
    end
  end

  // Pins, status and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_out <= 3'h0;
      pin_a_oe <= 3'h0;
      status <= 6'h00;
      mask <= 6'h00;
      irq <= 1'b0;
    end else begin
      pin_a_out <= next_out;
      pin_a_oe <= next_oe;
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  merge_or_cond_a: assert property ((cascade && merge_pin2a_enable && merge_pin1a_enable)
    |-> (cond1 == (pin_ch1_a | pin_ch2_a)) && (cond2 == cond1))
    else $error("merged capture condition is not the OR of both pins");

  event_ignores_pin_a: assert property ((io_control_ch1 == CAP_EVENT) |-> (cap1 == ch0_event))
    else $error("ch1 event capture follows something other than the ch0 event");

  rise_only_cap_a: assert property ((io_control_ch2 == CAP_RISE && cap2) |-> $rose(cond2))
    else $error("rising capture fired without a rising edge");

  gra_capture_a: assert property ((cap2 && !we_cnt2) |=> general_reg_a_ch2 == $past(lower_counter_ch2))
    else $error("capture did not store the counter");

  pin_off_a: assert property (!(pin_function_selector[1] && output_enable_reg[1]) |=> !pin_a_oe[1])
    else $error("pin driven without function select");

  stop_holds_a: assert property ((!count_start_reg[0] && !we_cnt0) |=> $stable(cnt0))
    else $error("counter moved while stopped");

  run_counts_a: assert property ((count_start_reg[2] && !we_cnt2) |=> lower_counter_ch2 == $past(lower_counter_ch2) + 16'h0001)
    else $error("running counter did not advance");

  match_low_a: assert property ((io_control_ch0 == IO_INIT_HI_LO && match0 && !we_io0) |=> !pin_a_out[0])
    else $error("output did not drop on compare match");

  cascade_carry_a: assert property ((cascade && count_start_reg[1] && count_start_reg[2]
    && lower_counter_ch2 == CNT_MAX && !we_cnt1 && !we_cnt2)
    |=> (upper_counter_ch1 == $past(upper_counter_ch1) + 16'h0001) && (lower_counter_ch2 == CNT_RESET))
    else $error("ch1 did not take the ch2 wrap");

  cascade_hold_a: assert property ((cascade && !carry2 && !we_cnt1) |=> $stable(upper_counter_ch1))
    else $error("cascaded ch1 moved without a wrap");

  irq_level_a: assert property (irq == |(status & mask))
    else $error("interrupt does not follow status and mask");

  merged_capture_c: cover property (cascade && merge_pin2a_enable && merge_pin1a_enable && cap1 && cap2);
  event_capture_c: cover property (io_control_ch1 == CAP_EVENT && cap1);
  cascade_wrap_c: cover property (cascade && carry2);
  match_drop_c: cover property (io_control_ch0 == IO_INIT_HI_LO && match0 ##1 !pin_a_out[0]);
endmodule : ccct_top

// ==== ccct_pkg.sv ====
// Constants, register map and decode helpers for the cascaded capture timer
package ccct_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_OE = 8'h08;
  localparam logic [7:0] OFF_MERGE = 8'h0c;
  localparam logic [7:0] OFF_IO0 = 8'h10;
  localparam logic [7:0] OFF_IO1 = 8'h14;
  localparam logic [7:0] OFF_IO2 = 8'h18;
  localparam logic [7:0] OFF_GRA0 = 8'h1c;
  localparam logic [7:0] OFF_GRA1 = 8'h20;
  localparam logic [7:0] OFF_GRA2 = 8'h24;
  localparam logic [7:0] OFF_CNT0 = 8'h28;
  localparam logic [7:0] OFF_CNT1 = 8'h2c;
  localparam logic [7:0] OFF_CNT2 = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  localparam logic [7:0] OFF_MASK = 8'h38;
  localparam logic [7:0] OFF_PFSEL = 8'h3c;
  // Field positions
  localparam int MODE_CASCADE_BIT = 0;
  localparam int MERGE_PIN2A_BIT = 0;
  localparam int MERGE_PIN1A_BIT = 1;
  localparam int STAT_MATCH_LSB = 0;
  localparam int STAT_CAP_LSB = 3;
  // Reset values and counter top value
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] GRA_RESET = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [3:0] IO_RESET = 4'h0;
  localparam logic TIMER_MODE_RESET = 1'b0;
  // I/O control field encodings: compare output levels and capture timing
  localparam logic [3:0] IO_OFF = 4'h0;
  localparam logic [3:0] IO_INIT_LO_HI = 4'h1;
  localparam logic [3:0] IO_INIT_HI_LO = 4'h2;
  localparam logic [3:0] IO_INIT_LO_TOG = 4'h3;
  localparam logic [3:0] CAP_RISE = 4'h8;
  localparam logic [3:0] CAP_FALL = 4'h9;
  localparam logic [3:0] CAP_BOTH = 4'ha;
  localparam logic [3:0] CAP_EVENT = 4'hc;

  function automatic logic is_output(input logic [3:0] mode);
    is_output = (mode == IO_INIT_LO_HI) || (mode == IO_INIT_HI_LO) || (mode == IO_INIT_LO_TOG);
  endfunction : is_output

  function automatic logic init_level(input logic [3:0] mode);
    init_level = (mode == IO_INIT_HI_LO);
  endfunction : init_level

  function automatic logic match_level(input logic [3:0] mode, input logic cur);
    case (mode)
      IO_INIT_LO_HI: match_level = 1'b1;
      IO_INIT_HI_LO: match_level = 1'b0;
      IO_INIT_LO_TOG: match_level = ~cur;
      default: match_level = cur;
    endcase
  endfunction : match_level

  function automatic logic cap_hit(input logic [3:0] mode, input logic prev, input logic cur,
                                   input logic evt);
    case (mode)
      CAP_RISE: cap_hit = cur & ~prev;
      CAP_FALL: cap_hit = prev & ~cur;
      CAP_BOTH: cap_hit = cur ^ prev;
      CAP_EVENT: cap_hit = evt;
      default: cap_hit = 1'b0;
    endcase
  endfunction : cap_hit
endpackage : ccct_pkg

// ==== ccct_counter16.sv ====
// Sixteen-bit up counter with load and wrap carry
`timescale 1ns/1ps
module ccct_counter16
  import ccct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic inc,
  input wire logic load,
  input wire logic [15:0] load_val,
  // State
  output logic [15:0] count,
  output logic carry
);
  logic [15:0] next_count;

  // Bus load beats counting in the same cycle
  assign next_count = load ? load_val : (inc ? count + 16'h0001 : count);
  assign carry = inc & ~load & (count == CNT_MAX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= CNT_RESET;
    end else begin
      count <= next_count;
    end
  end
endmodule : ccct_counter16

// ==== ccct_capsel.sv ====
// Capture trigger selector: edge detection or cross-channel event
`timescale 1ns/1ps
module ccct_capsel
  import ccct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Selection and sources
  input wire logic [3:0] mode,
  input wire logic sig,
  input wire logic evt,
  // Trigger
  output logic hit
);
  logic prev;

  // Event mode looks only at evt, so merged pins are ignored there
  assign hit = cap_hit(mode, prev, sig, evt);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end
endmodule : ccct_capsel

// ==== ccct_top_test.sv ====
// Self-checking testbench for the cascaded capture timer
`timescale 1ns/1ps
module ccct_top_test;
  import ccct_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] pin_a_in;
  logic [2:0] pin_a_out;
  logic [2:0] pin_a_oe;
  logic irq;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] reg_q[$];
  logic [6:0] pin_q[$];
  logic [31:0] reg_got;
  event reg_ev;
  event pin_ev;
  logic [15:0] v0, v1, v2, g;
  logic [31:0] a, b;
  logic [3:0] modes [3];
  int i;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  ccct_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t irq/oe/out %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // One single AHB transfer; entered right after a rising edge
  task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, adr};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, adr, d, r);
  endtask : wr

  task automatic rdv(input logic [7:0] adr, output logic [31:0] r);
    bus(1'b0, adr, 32'h0, r);
  endtask : rdv

  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    reg_q.push_back(exp);
    reg_got = got;
    ->reg_ev;
  endtask : note

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    rdv(adr, r);
    note(r, exp);
  endtask : rd

  // Two edges let registered pin and irq outputs follow a register write
  task automatic pins(input logic [6:0] exp);
    pin_q.push_back(exp);
    repeat (2) @(posedge hclk);
    #1;
    ->pin_ev;
    @(posedge hclk);
  endtask : pins

  initial forever begin
    @(reg_ev);
    chk_reg(reg_got, reg_q.pop_front());
  end

  initial forever begin
    @(pin_ev);
    chk_pin({irq, pin_a_oe, pin_a_out}, pin_q.pop_front());
  end

  initial begin
    repeat (6000) @(posedge hclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    pin_a_in = 3'b000;
    modes = '{CAP_RISE, CAP_FALL, CAP_BOTH};
    void'($urandom(32'hef9ec0a7));
    // Two edges here plus three inside pins make five edges of reset
    repeat (2) @(posedge hclk);
    pins(7'h00);
    hresetn <= 1'b1;
    @(posedge hclk);
    note({30'h0, hresp, hreadyout}, 32'h1);
    rd(OFF_MODE, 32'h0);
    rd(OFF_GRA0, {16'h0, GRA_RESET});
    rd(OFF_CNT0, 32'h0);
    rd(OFF_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    // Compare output, initial high then low on match
    g = 16'h0010 + 16'($urandom_range(63));
    wr(OFF_GRA0, {16'h0, g});
    wr(OFF_CNT0, 32'h0);
    wr(OFF_MASK, 32'h1);
    wr(OFF_OE, 32'h1);
    wr(OFF_IO0, {28'h0, IO_INIT_HI_LO});
    pins(7'h01);
    wr(OFF_PFSEL, 32'h1);
    pins(7'h09);
    wr(OFF_START, 32'h1);
    pins(7'h09);
    for (i = 0; i < 300 && pin_a_out[0] !== 1'b0; i++) @(posedge hclk);
    pins(7'h48);
    rd(OFF_STATUS, 32'h1);
    // Error recovery: park pin, stop, mask and clear, reinitialise, reselect pin
    wr(OFF_PFSEL, 32'h0);
    wr(OFF_START, 32'h0);
    pins(7'h40);
    wr(OFF_MASK, 32'h0);
    pins(7'h00);
    wr(OFF_MASK, 32'h1);
    pins(7'h40);
    wr(OFF_STATUS, 32'h1);
    pins(7'h00);
    wr(OFF_IO0, {28'h0, IO_INIT_HI_LO});
    wr(OFF_PFSEL, 32'h1);
    pins(7'h09);
    wr(OFF_PFSEL, 32'h0);
    wr(OFF_OE, 32'h0);
    wr(OFF_MASK, 32'h0);
    // Hold while stopped, advance one per clock while started
    v0 = 16'($urandom_range(32767));
    wr(OFF_CNT0, {16'h0, v0});
    repeat (10) @(posedge hclk);
    rd(OFF_CNT0, {16'h0, v0});
    wr(OFF_START, 32'h1);
    rdv(OFF_CNT0, a);
    rdv(OFF_CNT0, b);
    note(b - a, 32'd2);
    wr(OFF_START, 32'h0);
    rdv(OFF_CNT0, a);
    repeat (10) @(posedge hclk);
    rd(OFF_CNT0, a);
    // Edge selections of the capture field, stopped counter
    for (i = 0; i < 3; i++) begin
      v0 = 16'($urandom());
      wr(OFF_CNT0, {16'h0, v0});
      wr(OFF_GRA0, 32'hffff);
      wr(OFF_IO0, {28'h0, modes[i]});
      pin_a_in[0] <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(OFF_GRA0, (modes[i] != CAP_FALL) ? {16'h0, v0} : 32'hffff);
      wr(OFF_GRA0, 32'hffff);
      pin_a_in[0] <= 1'b0;
      repeat (2) @(posedge hclk);
      rd(OFF_GRA0, (modes[i] != CAP_RISE) ? {16'h0, v0} : 32'hffff);
    end
    // Cascade with both merges: either pin captures into both channels
    v1 = 16'($urandom());
    v2 = 16'($urandom());
    wr(OFF_MODE, 32'h1);
    wr(OFF_MERGE, 32'h3);
    wr(OFF_IO1, {28'h0, CAP_BOTH});
    wr(OFF_IO2, {28'h0, CAP_BOTH});
    wr(OFF_CNT1, {16'h0, v1});
    wr(OFF_CNT2, {16'h0, v2});
    wr(OFF_STATUS, 32'h3f);
    for (i = 1; i < 3; i++) begin
      wr(OFF_GRA1, 32'hffff);
      wr(OFF_GRA2, 32'hffff);
      pin_a_in[i] <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(OFF_GRA1, {16'h0, v1});
      rd(OFF_GRA2, {16'h0, v2});
      if (i == 1) rd(OFF_STATUS, 32'h30);
      pin_a_in[i] <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    // Event-timed ch1 ignores the merged ch2 pin
    wr(OFF_MERGE, 32'h1);
    wr(OFF_IO1, {28'h0, CAP_EVENT});
    wr(OFF_IO2, {28'h0, CAP_RISE});
    wr(OFF_IO0, {28'h0, CAP_RISE});
    wr(OFF_GRA1, 32'hffff);
    wr(OFF_GRA2, 32'hffff);
    pin_a_in[2] <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(OFF_GRA1, 32'hffff);
    rd(OFF_GRA2, {16'h0, v2});
    pin_a_in[0] <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(OFF_GRA1, {16'h0, v1});
    // Lower half starts at its top value so a short run wraps exactly once
    wr(OFF_CNT2, 32'hffff);
    wr(OFF_START, 32'h6);
    wr(OFF_START, 32'h0);
    rd(OFF_CNT1, {16'h0, v1 + 16'h1});
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule : ccct_top_test
